//--- hw/dbu_pkg.sv
// dbu_pkg: register map, field positions, reset values and modes of the
// display buffer unpack block. Used by dbu_top and by the tb bench.
package dbu_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MEM_CFG   = 6'h01;
  localparam logic [5:0] IDX_PANEL_CFG = 6'h02;
  localparam logic [5:0] IDX_HDISP     = 6'h04;
  localparam logic [5:0] IDX_VBLANK    = 6'h0A;
  localparam logic [5:0] IDX_DISP_EN   = 6'h0D;
  localparam logic [5:0] IDX_HOST_HBUF = 6'h1B;
  localparam logic [5:0] IDX_PERF      = 6'h22;
  localparam logic [5:0] IDX_FIFO      = 6'h23;
  localparam logic [5:0] IDX_CTAB_ADDR = 6'h24;
  localparam logic [5:0] IDX_CTAB_DATA = 6'h26;
  localparam logic [5:0] IDX_DISP_MODE = 6'h30;

  // field positions
  localparam int BIT_MEM_TYPE  = 0;
  localparam int BIT_DUAL      = 1;
  localparam int BIT_VBLANK    = 7;
  localparam int BIT_DISP_EN   = 0;
  localparam int BIT_HOST_OFF  = 7;
  localparam int BIT_HBUF_OFF  = 0;
  localparam int BIT_FIFO_OFF  = 7;
  localparam int BIT_COLOUR    = 3;

  // reset values
  localparam logic       RST_HOST_OFF = 1'b1;
  localparam logic       RST_HBUF_OFF = 1'b0;
  localparam logic       RST_FIFO_OFF = 1'b0;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // timing: half frame buffer must stop within this many pixel clocks
  localparam int HBUF_STOP_PCLK = 1024;

  // buffer sizes in bytes
  localparam int BUF_512K = 524288;
  localparam int BUF_2M   = 2097152;

  typedef enum logic [2:0] {
    DBU_BPP1,
    DBU_BPP2,
    DBU_BPP4,
    DBU_BPP8,
    DBU_BPP15,
    DBU_BPP16
  } dbu_bpp_t;

endpackage : dbu_pkg

//--- hw/dbu_ctab_mem.sv
// dbu_ctab_mem: one lane of the colour table, write port and registered read.
// Assumes a single clock shared with the writer.
`timescale 1ns/1ns
`default_nettype none
module dbu_ctab_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 4
) (
  input  wire logic                     hclk,   // clock
  input  wire logic                     we,     // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr,  // write address
  input  wire logic [WIDTH-1:0]         wdata,  // write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr,  // read address
  output logic      [WIDTH-1:0]         rdata   // registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];

  generate
    if (DEPTH < 2) begin : g_chk
      $error("dbu_ctab_mem: DEPTH must be at least 2");
    end
  endgenerate

  // no reset on contents: software loads the table before display
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : dbu_ctab_mem
`default_nettype wire

//--- hw/dbu_top.sv
// dbu_top: display buffer pixel unpack, half frame buffer gating and the
// init/control registers, reached over an AHB-Lite slave port.
// Assumes pixel bytes/words arrive from the fetch side with valid/ready and
// that the panel timing block supplies the vertical non-display level.
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Half frame buffer stays idle until the panel register is written.
// - Enabling the half frame buffer is accepted at any time.
// - Width zero stops half frame buffer accesses within 1024 pixel clocks.
// - Bit 7 of register 0Ah shows vertical blank; host waits one frame.
// - Display buffer is 512K or 2M bytes, placed externally.
// - 1 bpp: eight pixels a byte, leftmost in bit 7.
// - 1 bpp indexes entries 0/1: green table for gray, all for colour.
// - 2 bpp: four pixels a byte, first from bits 7:6.
// - 4 bpp: two pixels a byte, first from upper nibble.
// - 8 bpp: red 7:5, green 4:2, blue 1:0, own tables.
// - 8 bpp is allowed on a monochrome panel.
// - 15 bpp: bit 15 unused, red 14:10, green 9:5, blue 4:0.
// - 16 bpp: red 15:11, green 10:5, blue 4:0.
// - 15/16 bpp bypass the tables straight to the modulator.
// - Half frame buffer runs when dual, width nonzero and enabled.
module dbu_top
  import dbu_pkg::*;
#(
  parameter int BUF_BYTES = dbu_pkg::BUF_2M,
  parameter int PCLK_DIV  = 2
) (
  input  wire logic        hclk,         // 100 MHz clock
  input  wire logic        hresetn,      // async reset, active low
  input  wire logic        hsel,         // ahb slave select
  input  wire logic [7:0]  haddr,        // ahb byte address
  input  wire logic [1:0]  htrans,       // ahb transfer type
  input  wire logic        hwrite,       // ahb write
  input  wire logic [2:0]  hsize,        // ahb size, word only
  input  wire logic [31:0] hwdata,       // ahb write data
  input  wire logic        hready,       // ahb bus ready
  output logic      [31:0] hrdata,       // ahb read data
  output logic             hreadyout,    // ahb slave ready
  output logic             hresp,        // ahb response, always okay
  input  wire logic [15:0] buf_data,     // fetched buffer byte/word
  input  wire logic        buf_valid,    // fetched data valid
  output logic             buf_ready,    // unpacker takes data
  output logic      [20:0] fetch_addr,   // next buffer byte address
  input  wire logic        vblank_in,    // vertical non-display level
  output logic      [4:0]  out_red,      // red to modulator
  output logic      [5:0]  out_green,    // green to modulator
  output logic      [4:0]  out_blue,     // blue to modulator
  output logic             out_valid,    // one pixel, one-cycle pulse
  output logic             pclk_en,      // pixel clock enable
  output logic             hbuf_run,     // half frame buffer may access dram
  output logic             mem_type,     // memory type select
  output logic      [7:0]  perf,         // performance setting
  output logic             dual_panel,   // dual panel select
  output logic             host_if_off,  // host interface disabled
  output logic             fifo_off,     // display fifo disabled
  output logic             disp_en,      // display enable
  output logic      [7:0]  hdisp_width   // horizontal display width
);
  import dbu_pkg::*;

  generate
    if (BUF_BYTES != BUF_512K && BUF_BYTES != BUF_2M) begin : g_buf_chk
      $error("dbu_top: BUF_BYTES must be 512K or 2M");
    end
    if (PCLK_DIV < 1) begin : g_div_chk
      $error("dbu_top: PCLK_DIV must be at least 1");
    end
  endgenerate

  localparam logic [20:0] ADDR_MASK = 21'(BUF_BYTES - 1);
  localparam int          DIV_W     = (PCLK_DIV > 1) ? $clog2(PCLK_DIV) : 1;

  function automatic logic word_is(input logic [7:0] a, input logic [5:0] idx);
    return a[7:2] == idx;
  endfunction : word_is

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes zero wait, reads one wait so a write just ahead
  // has landed before the read data is sampled
  logic       ph_wr, ph_rd, rd_wait;
  logic [7:0] ph_addr;
  logic       next_ph_wr, next_ph_rd, next_rd_wait;
  logic [7:0] next_ph_addr;
  logic [31:0] next_hrdata;
  logic       take;
  logic       wr_now;
  logic       hbuf_off, panel_set, colour;
  logic [6:0] vnd_period;
  logic [2:0] bpp_raw;
  logic [1:0] ctab_sel, auto_lane;
  logic [3:0] ctab_addr;

  assign take      = hsel && htrans[1] && hready;
  assign wr_now    = ph_wr;
  assign hreadyout = !rd_wait;
  assign hresp     = 1'b0;

  always_comb begin
    next_ph_wr   = take && hwrite;
    next_ph_rd   = take && !hwrite;
    next_ph_addr = take ? haddr : ph_addr;
    next_rd_wait = take && !hwrite;
    next_hrdata  = hrdata;
    if (!hready) begin
      next_ph_wr   = ph_wr;
      next_ph_rd   = ph_rd;
      next_ph_addr = ph_addr;
      next_rd_wait = 1'b0;
    end
    if (ph_rd && rd_wait) begin
      next_hrdata = 32'h0000_0000;
      if (word_is(ph_addr, IDX_MEM_CFG)) begin
        next_hrdata[BIT_MEM_TYPE] = mem_type;
      end else if (word_is(ph_addr, IDX_PANEL_CFG)) begin
        next_hrdata[BIT_DUAL] = dual_panel;
      end else if (word_is(ph_addr, IDX_HDISP)) begin
        next_hrdata[7:0] = hdisp_width;
      end else if (word_is(ph_addr, IDX_VBLANK)) begin
        next_hrdata[7:0] = {vblank_in, vnd_period};
      end else if (word_is(ph_addr, IDX_DISP_EN)) begin
        next_hrdata[BIT_DISP_EN] = disp_en;
      end else if (word_is(ph_addr, IDX_HOST_HBUF)) begin
        next_hrdata[BIT_HOST_OFF] = host_if_off;
        next_hrdata[BIT_HBUF_OFF] = hbuf_off;
      end else if (word_is(ph_addr, IDX_PERF)) begin
        next_hrdata[7:0] = perf;
      end else if (word_is(ph_addr, IDX_FIFO)) begin
        next_hrdata[BIT_FIFO_OFF] = fifo_off;
      end else if (word_is(ph_addr, IDX_CTAB_ADDR)) begin
        next_hrdata[5:0] = {ctab_sel, ctab_addr};
      end else if (word_is(ph_addr, IDX_DISP_MODE)) begin
        next_hrdata[3:0] = {colour, bpp_raw};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      rd_wait <= 1'b0;
      ph_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      ph_wr   <= next_ph_wr;
      ph_rd   <= next_ph_rd;
      rd_wait <= next_rd_wait;
      ph_addr <= next_ph_addr;
      hrdata  <= next_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic       next_mem_type, next_dual, next_host_off, next_hbuf_off, next_fifo_off;
  logic       next_disp_en, next_panel_set, next_colour;
  logic [7:0] next_perf, next_hdisp;
  logic [6:0] next_vnd_period;
  logic [2:0] next_bpp_raw;
  logic [1:0] next_ctab_sel, next_auto_lane;
  logic [3:0] next_ctab_addr;
  logic [2:0] ctab_we;
  logic [1:0] lane;

  always_comb begin
    next_mem_type   = mem_type;
    next_dual       = dual_panel;
    next_host_off   = host_if_off;
    next_hbuf_off   = hbuf_off;
    next_fifo_off   = fifo_off;
    next_disp_en    = disp_en;
    next_panel_set  = panel_set;
    next_colour     = colour;
    next_perf       = perf;
    next_hdisp      = hdisp_width;
    next_vnd_period = vnd_period;
    next_bpp_raw    = bpp_raw;
    next_ctab_sel   = ctab_sel;
    next_ctab_addr  = ctab_addr;
    next_auto_lane  = auto_lane;
    ctab_we         = 3'b000;
    lane            = (ctab_sel == 2'b00) ? auto_lane : 2'(ctab_sel - 2'd1);
    if (wr_now) begin
      if (word_is(ph_addr, IDX_MEM_CFG)) begin
        next_mem_type = hwdata[BIT_MEM_TYPE];
      end else if (word_is(ph_addr, IDX_PANEL_CFG)) begin
        // panel write arms the half frame buffer
        next_dual      = hwdata[BIT_DUAL];
        next_panel_set = 1'b1;
      end else if (word_is(ph_addr, IDX_HDISP)) begin
        next_hdisp = hwdata[7:0];
      end else if (word_is(ph_addr, IDX_VBLANK)) begin
        next_vnd_period = hwdata[6:0];
      end else if (word_is(ph_addr, IDX_DISP_EN)) begin
        next_disp_en = hwdata[BIT_DISP_EN];
      end else if (word_is(ph_addr, IDX_HOST_HBUF)) begin
        // enable taken at once, no sync needed
        next_host_off = hwdata[BIT_HOST_OFF];
        next_hbuf_off = hwdata[BIT_HBUF_OFF];
      end else if (word_is(ph_addr, IDX_PERF)) begin
        next_perf = hwdata[7:0];
      end else if (word_is(ph_addr, IDX_FIFO)) begin
        next_fifo_off = hwdata[BIT_FIFO_OFF];
      end else if (word_is(ph_addr, IDX_CTAB_ADDR)) begin
        next_ctab_sel  = hwdata[5:4];
        next_ctab_addr = hwdata[3:0];
        next_auto_lane = 2'd0;
      end else if (word_is(ph_addr, IDX_CTAB_DATA)) begin
        ctab_we[lane] = 1'b1;
        // with select zero, auto-increment walks red, green, blue, then the next entry; a selected lane steps the entry each write
        if (ctab_sel != 2'b00) begin
          next_ctab_addr = ctab_addr + 4'd1;
        end else if (auto_lane == 2'd2) begin
          next_auto_lane = 2'd0;
          next_ctab_addr = ctab_addr + 4'd1;
        end else begin
          next_auto_lane = auto_lane + 2'd1;
        end
      end else if (word_is(ph_addr, IDX_DISP_MODE)) begin
        next_bpp_raw = hwdata[2:0];
        next_colour  = hwdata[BIT_COLOUR];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_type    <= 1'b0;
      dual_panel  <= 1'b0;
      host_if_off <= RST_HOST_OFF;
      hbuf_off    <= RST_HBUF_OFF;
      fifo_off    <= RST_FIFO_OFF;
      disp_en     <= 1'b0;
      panel_set   <= 1'b0;
      colour      <= 1'b0;
      perf        <= RST_BYTE;
      hdisp_width <= RST_BYTE;
      vnd_period  <= 7'h00;
      bpp_raw     <= 3'd0;
      ctab_sel    <= 2'd0;
      ctab_addr   <= 4'h0;
      auto_lane   <= 2'd0;
    end else begin
      mem_type    <= next_mem_type;
      dual_panel  <= next_dual;
      host_if_off <= next_host_off;
      hbuf_off    <= next_hbuf_off;
      fifo_off    <= next_fifo_off;
      disp_en     <= next_disp_en;
      panel_set   <= next_panel_set;
      colour      <= next_colour;
      perf        <= next_perf;
      hdisp_width <= next_hdisp;
      vnd_period  <= next_vnd_period;
      bpp_raw     <= next_bpp_raw;
      ctab_sel    <= next_ctab_sel;
      ctab_addr   <= next_ctab_addr;
      auto_lane   <= next_auto_lane;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half frame buffer gate and pixel clock enable
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic             next_hbuf_run, next_pclk_en;

  always_comb begin
    // run only once armed, dual, enabled, width nonzero
    // width zero drops the request on the next clock
    next_hbuf_run = panel_set && dual_panel && !hbuf_off && (hdisp_width != 8'h00);
    next_pclk_en = (div_cnt == DIV_W'(PCLK_DIV - 1));
    next_div_cnt = next_pclk_en ? '0 : div_cnt + DIV_W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hbuf_run <= 1'b0;
      pclk_en <= 1'b0;
      div_cnt <= '0;
    end else begin
      hbuf_run <= next_hbuf_run;
      pclk_en <= next_pclk_en;
      div_cnt <= next_div_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unpacker: one pixel per pixel clock enable, msb-first within a byte
  dbu_bpp_t   bpp;
  logic [15:0] hold, next_hold;
  logic [3:0]  left, next_left, per_xfer;
  logic [20:0] next_fetch_addr;
  logic        emit, take_buf;
  logic [3:0]  idx [3];
  logic [3:0]  tab [3];
  logic        st_valid, st_bypass, st_mono, next_st_bypass, next_st_mono;
  logic [15:0] st_pix, next_st_pix;
  logic [4:0]  next_out_red, next_out_blue;
  logic [5:0]  next_out_green;

  assign bpp = (bpp_raw > 3'd5) ? DBU_BPP16 : dbu_bpp_t'(bpp_raw);
  assign emit      = pclk_en && (left != 4'd0);
  assign buf_ready = !fifo_off && ((left == 4'd0) || (left == 4'd1 && pclk_en));
  assign take_buf  = buf_ready && buf_valid;

  always_comb begin
    per_xfer        = 4'd1;
    next_hold       = hold;
    next_left       = left;
    next_fetch_addr = fetch_addr;
    next_st_pix     = hold;
    next_st_bypass  = st_bypass;
    next_st_mono    = st_mono;
    idx[0]          = 4'h0;
    idx[1]          = 4'h0;
    idx[2]          = 4'h0;
    case (bpp)
      DBU_BPP1: begin
        per_xfer = 4'd8;
        idx[1]   = {3'b000, hold[7]};
      end
      DBU_BPP2: begin
        per_xfer = 4'd4;
        idx[1]   = {2'b00, hold[7:6]};
      end
      DBU_BPP4: begin
        per_xfer = 4'd2;
        idx[1]   = hold[7:4];
      end
      DBU_BPP8: begin
        idx[0] = {1'b0, hold[7:5]};
        idx[1] = {1'b0, hold[4:2]};
        idx[2] = {2'b00, hold[1:0]};
      end
      default: begin
        idx[1] = 4'h0;
      end
    endcase
    // 1, 2 and 4 bpp index all three tables alike
    if (bpp inside {DBU_BPP1, DBU_BPP2, DBU_BPP4}) begin
      idx[0] = idx[1];
      idx[2] = idx[1];
    end
    if (emit) begin
      next_left      = left - 4'd1;
      next_hold      = hold << (4'd8 / per_xfer);
      next_st_bypass = (bpp == DBU_BPP15) || (bpp == DBU_BPP16);
      next_st_mono   = !colour && (bpp != DBU_BPP8);
    end
    if (fifo_off) begin
      next_left       = 4'd0;
      next_fetch_addr = 21'h00_0000;
    end else if (take_buf) begin
      next_hold = buf_data;
      next_left = per_xfer;
      // byte address wraps at the buffer size
      next_fetch_addr = (fetch_addr + ((bpp >= DBU_BPP15) ? 21'd2 : 21'd1)) & ADDR_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ctab
      dbu_ctab_mem #(.DEPTH(16), .WIDTH(4)) u_ctab (
        .hclk  (hclk),
        .we    (ctab_we[g]),
        .waddr (ctab_addr),
        .wdata (hwdata[3:0]),
        .raddr (idx[g]),
        .rdata (tab[g])
      );
    end
  endgenerate

  always_comb begin
    next_out_red   = {tab[0], 1'b0};
    next_out_green = {tab[1], 2'b00};
    next_out_blue  = {tab[2], 1'b0};
    if (st_bypass) begin
      // field split differs in red and green, blue is shared
      if (bpp == DBU_BPP15) begin
        next_out_red   = st_pix[14:10];
        next_out_green = {st_pix[9:5], 1'b0};
      end else begin
        next_out_red   = st_pix[15:11];
        next_out_green = st_pix[10:5];
      end
      next_out_blue = st_pix[4:0];
    end else if (st_mono) begin
      // gray uses the green table only
      next_out_red  = 5'h00;
      next_out_blue = 5'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold       <= 16'h0000;
      left       <= 4'd0;
      fetch_addr <= 21'h00_0000;
      st_valid   <= 1'b0;
      st_bypass  <= 1'b0;
      st_mono    <= 1'b0;
      st_pix     <= 16'h0000;
      out_valid  <= 1'b0;
      out_red    <= 5'h00;
      out_green  <= 6'h00;
      out_blue   <= 5'h00;
    end else begin
      hold       <= next_hold;
      left       <= next_left;
      fetch_addr <= next_fetch_addr;
      st_valid   <= emit;
      st_bypass  <= next_st_bypass;
      st_mono    <= next_st_mono;
      st_pix     <= emit ? next_st_pix : st_pix;
      out_valid  <= st_valid;
      out_red    <= st_valid ? next_out_red : out_red;
      out_green  <= st_valid ? next_out_green : out_green;
      out_blue   <= st_valid ? next_out_blue : out_blue;
    end
  end

endmodule : dbu_top
`default_nettype wire

//--- sim/dbu_top_props.sv
// dbu_top_props: timing checks on the ports of the unpack block.
// assumes one clock domain and the word-only register bus.
`timescale 1ns/1ns
`default_nettype none
module dbu_top_props #(
  parameter int BUF_BYTES = 2097152,
  parameter int PCLK_DIV  = 2
) (
  input wire logic        hclk,        // clock
  input wire logic        hresetn,     // reset, active low
  input wire logic        hsel,        // slave select
  input wire logic [1:0]  htrans,      // transfer type
  input wire logic        hwrite,      // write
  input wire logic        hready,      // bus ready
  input wire logic        hreadyout,   // slave ready
  input wire logic        buf_ready,   // data taken
  input wire logic [20:0] fetch_addr,  // buffer address
  input wire logic [4:0]  out_red,     // red
  input wire logic [5:0]  out_green,   // green
  input wire logic [4:0]  out_blue,    // blue
  input wire logic        out_valid,   // pixel pulse
  input wire logic        pclk_en,     // pixel clock
  input wire logic        hbuf_run,    // half frame buffer on
  input wire logic        dual_panel,  // dual panel
  input wire logic        fifo_off,    // fifo disabled
  input wire logic [7:0]  hdisp_width  // display width
);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_run_cause;
    hbuf_run |-> $past(dual_panel) && $past(hdisp_width) != 8'h00;
  endproperty
  property p_run_stop;
    hdisp_width == 8'h00 |=> !hbuf_run;
  endproperty
  property p_fifo_rdy;
    fifo_off |-> !buf_ready;
  endproperty
  property p_fifo_addr;
    fifo_off |=> fetch_addr == 21'h0;
  endproperty
  property p_buf_size;
    {11'h0, fetch_addr} < BUF_BYTES;
  endproperty
  property p_pix_time;
    out_valid |-> $past(pclk_en, 2);
  endproperty
  property p_pix_hold;
    !out_valid |-> $stable({out_red, out_green, out_blue});
  endproperty
  property p_pclk;
    pclk_en |-> ##PCLK_DIV pclk_en;
  endproperty
  property p_rd_wait;
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout;
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("run without cause");
  a_run_stop: assert property (p_run_stop) else $error("run with zero width");
  a_fifo_rdy: assert property (p_fifo_rdy) else $error("ready while fifo off");
  a_fifo_addr: assert property (p_fifo_addr) else $error("address kept while fifo off");
  a_buf_size: assert property (p_buf_size) else $error("address beyond buffer");
  a_pix_time: assert property (p_pix_time) else $error("pixel off its slot");
  a_pix_hold: assert property (p_pix_hold) else $error("pixel moved between pulses");
  a_pclk: assert property (p_pclk) else $error("pixel clock period");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state");
  cover property ($rose(hbuf_run));
  cover property (out_valid);
  cover property ($fell(hbuf_run) && hdisp_width == 8'h00);
endmodule : dbu_top_props
bind dbu_top dbu_top_props #(.BUF_BYTES(BUF_BYTES), .PCLK_DIV(PCLK_DIV)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .buf_ready(buf_ready), .fetch_addr(fetch_addr),
  .out_red(out_red), .out_green(out_green), .out_blue(out_blue), .out_valid(out_valid),
  .pclk_en(pclk_en), .hbuf_run(hbuf_run), .dual_panel(dual_panel), .fifo_off(fifo_off),
  .hdisp_width(hdisp_width));
`default_nettype wire

//--- sim/dbu_src.sv
// dbu_src: fetch side model offering one buffer word at a time.
// assumes the bench hands words over by a one-cycle load pulse.
`timescale 1ns/1ns
`default_nettype none
module dbu_src (
  input  wire logic        hclk,       // clock
  input  wire logic        hresetn,    // reset, active low
  input  wire logic        ld,         // word handed over
  input  wire logic [15:0] word,       // word to offer
  input  wire logic        stall,      // hold the offer back
  input  wire logic        buf_ready,  // unpacker takes data
  output logic      [15:0] buf_data,   // offered data
  output logic             buf_valid   // offer standing
);
  logic        pend;
  logic [15:0] held;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      held <= 16'h0000;
      buf_valid <= 1'b0;
      buf_data <= 16'hFFFF;
    end else begin
      // taken data is gone: show its inverse, not a stale copy
      if (buf_valid && buf_ready) begin
        buf_valid <= 1'b0;
        buf_data <= ~buf_data;
      end else if (pend && !stall && !buf_valid) begin
        buf_valid <= 1'b1;
        buf_data <= held;
        pend <= 1'b0;
      end
      if (ld) begin
        pend <= 1'b1;
        held <= word;
      end
    end
  end
endmodule : dbu_src
`default_nettype wire

//--- sim/tb.sv
// tb: register sequences and pixel unpacking of the display buffer block.
// assumes the bus master is this bench and dbu_src feeds pixel words.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module tb;
  import dbu_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, vblank_in = 0, ld = 0, stall = 0;
  logic [7:0]  haddr = 0, perf, hdisp_width;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic [15:0] word = 0, buf_data;
  logic [20:0] fetch_addr;
  logic [4:0]  out_red, out_blue;
  logic [5:0]  out_green;
  logic        hreadyout, hresp, buf_valid, buf_ready, out_valid, pclk_en, hbuf_run;
  logic        mem_type, dual_panel, host_if_off, fifo_off, disp_en;
  int          fail_count = 0, checks_done = 0;
  dbu_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .buf_data, .buf_valid, .buf_ready,
    .fetch_addr, .vblank_in, .out_red, .out_green, .out_blue, .out_valid, .pclk_en,
    .hbuf_run, .mem_type, .perf, .dual_panel, .host_if_off, .fifo_off, .disp_en, .hdisp_width);
  dbu_src src (.hclk, .hresetn, .ld, .word, .stall, .buf_ready, .buf_data, .buf_valid);
  always #5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // one spare edge so register outputs have landed
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
    @(posedge hclk);
  endtask : wr
  task automatic rdc(input logic [5:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rdc
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  // reset state
  task automatic t_reset;
    `CHK({host_if_off, fifo_off, hbuf_run, hresp}, 4'b1000)
    rdc(IDX_HOST_HBUF, 32'h0000_0080);
    wr(6'h3F, 32'hFFFF_FFFF);
    rdc(6'h3F, 32'h0000_0000);
  endtask : t_reset
  task automatic t_init;
    wr(IDX_HOST_HBUF, 32'h0000_0000);
    `CHK(host_if_off, 1'b0)
    wr(IDX_FIFO, 32'h0000_0080);
    `CHK({fifo_off, buf_ready}, 2'b10)
    wr(IDX_MEM_CFG, 32'h0000_0001);
    wr(IDX_PERF, 32'h0000_0024);
    wr(IDX_HDISP, 32'h0000_004F);
    @(posedge hclk);
    `CHK(hbuf_run, 1'b0)
    wr(IDX_PANEL_CFG, 32'h0000_0002);
    @(posedge hclk);
    `CHK(hbuf_run, 1'b1)
    `CHK({mem_type, perf, dual_panel, hdisp_width}, {1'b1, 8'h24, 1'b1, 8'h4F})
    wr(IDX_FIFO, 32'h0000_0000);
    wr(IDX_DISP_EN, 32'h0000_0001);
    `CHK({fifo_off, disp_en}, 2'b01)
  endtask : t_init
  task automatic t_hbuf;
    wr(IDX_FIFO, 32'h0000_0080);
    wr(IDX_HDISP, 32'h0000_0000);
    @(posedge hclk);
    `CHK(hbuf_run, 1'b0)
    for (int k = 0; k < 3; k++) begin
      vblank_in <= (k != 1);
      rdc(IDX_VBLANK, (k != 1) ? 32'h0000_0080 : 32'h0000_0000);
    end
    wr(IDX_HOST_HBUF, 32'h0000_0001);
    wr(IDX_HDISP, 32'h0000_004F);
    @(posedge hclk);
    `CHK(hbuf_run, 1'b0)
    wr(IDX_HOST_HBUF, 32'h0000_0000);
    @(posedge hclk);
    `CHK(hbuf_run, 1'b1)
    wr(IDX_FIFO, 32'h0000_0000);
  endtask : t_hbuf
  // tables: red i, green 15-i, blue i^5
  task automatic t_ctab;
    wr(IDX_CTAB_ADDR, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      wr(IDX_CTAB_DATA, i);
      wr(IDX_CTAB_DATA, 15 - i);
      wr(IDX_CTAB_DATA, i ^ 5);
    end
  endtask : t_ctab
  task automatic pix(input logic [2:0] m, input logic c, input logic [15:0] d, input logic s);
    int          b, n, t;
    logic [3:0]  p;
    logic [15:0] e;
    wr(IDX_DISP_MODE, {28'h0, c, m});
    b = (m < 3) ? (1 << m) : 8;
    n = (m < 3) ? 8 / b : 1;
    stall <= s;
    word <= d;
    ld <= 1'b1;
    @(posedge hclk);
    ld <= 1'b0;
    if (s) repeat (6) @(posedge hclk);
    stall <= 1'b0;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do @(posedge hclk); while (out_valid !== 1'b1 && ++t < 64);
      p = 4'((d[7:0] >> (8 - b * (k + 1))) & ((1 << b) - 1));
      if (m < 3) e = c ? {p, 1'b0, ~p, 2'b0, p ^ 4'h5, 1'b0} : {5'h0, ~p, 2'b0, 5'h0};
      else if (m == 3) e = {1'b0, d[7:5], 1'b0, ~{1'b0, d[4:2]}, 2'b0, {2'b0, d[1:0]} ^ 4'h5, 1'b0};
      else e = (m == 4) ? {d[14:10], d[9:5], 1'b0, d[4:0]} : d;
      `CHK({out_red, out_green, out_blue}, e)
    end
  endtask : pix
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_init;
    t_hbuf;
    t_ctab;
    pix(3'd0, 1'b0, 16'h00A6, 1'b1);
    pix(3'd0, 1'b1, 16'h0059, 1'b0);
    pix(3'd1, 1'b1, 16'h001B, 1'b0);
    pix(3'd2, 1'b0, 16'h005E, 1'b1);
    pix(3'd3, 1'b1, 16'h00AE, 1'b0);
    pix(3'd3, 1'b0, 16'h0053, 1'b0);
    pix(3'd4, 1'b1, 16'hFBCD, 1'b0);
    pix(3'd5, 1'b0, 16'hA5C3, 1'b0);
    `CHK(fetch_addr, 21'h00_000A)
    finish_test;
  end
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
endmodule : tb
`default_nettype wire
